// [hdl/icc_defines.svh]
// Constants for the input capture channel: offsets, fields, counts
`ifndef ICC_DEFINES_SVH
`define ICC_DEFINES_SVH

// Register byte offsets
`define ICC_CTRL_OFS 4'h0
`define ICC_BUF_OFS 4'h4
// Control field positions
`define ICC_SIDL_BIT 13
`define ICC_TSEL_BIT 7
`define ICC_CPI_HI 6
`define ICC_CPI_LO 5
`define ICC_OVF_BIT 4
`define ICC_BNE_BIT 3
`define ICC_MODE_HI 2
`define ICC_MODE_LO 0
// Write mask of the control register (software bits only)
`define ICC_CTRL_WMASK 16'h20e7
`define ICC_CTRL_RST 16'h0000
// Capture buffer depth
`define ICC_BUF_DEPTH 4
// Last prescaler count of the every-4th and every-16th rising modes
`define ICC_DIV4_LAST 4'h3
`define ICC_DIV16_LAST 4'hf
// AXI responses
`define ICC_RESP_OKAY 2'h0
`define ICC_RESP_SLVERR 2'h2

`endif

// [hdl/icc_pkg.sv]
// Types shared by the input capture channel
`default_nettype none
package icc_pkg;
  typedef enum logic [2:0] {
    ICC_OFF = 3'h0,
    ICC_EVERY_EDGE = 3'h1,
    ICC_MODE2 = 3'h2,
    ICC_MODE3 = 3'h3,
    ICC_MODE4 = 3'h4,
    ICC_MODE5 = 3'h5,
    ICC_UNUSED = 3'h6,
    ICC_WAKE_PIN = 3'h7
  } icc_mode_e;
endpackage
`default_nettype wire

// [hdl/icc_edge_det.sv]
// Edge detector and event prescaler for the capture pin
`default_nettype none
`include "icc_defines.svh"
module icc_edge_det (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Control
  input wire logic run,
  input wire logic [2:0] mode,
  // Pin and event
  input wire logic pin,
  output logic evt,
  output logic rise
);
  logic prev_q, prev_d;
  logic [3:0] cnt_q, cnt_d;
  logic r, f;

  // Edge and divide-by-N counting; counts restart when halted
  always_comb
  begin
    r = pin & ~prev_q;
    f = ~pin & prev_q;
    prev_d = pin;
    cnt_d = 4'h0;
    evt = 1'b0;
    rise = r;
    if (!run)
    begin
      cnt_d = 4'h0;
    end
    else
    begin
      unique case (mode)
        icc_pkg::ICC_EVERY_EDGE: evt = r | f;
        icc_pkg::ICC_MODE2: evt = f;
        icc_pkg::ICC_MODE3: evt = r;
        icc_pkg::ICC_MODE4, icc_pkg::ICC_MODE5:
        begin
          // Only these modes keep the count, so a stale count carries over only between ICC_MODE4 and ICC_MODE5
          cnt_d = cnt_q;
          if (r)
          begin
            if (cnt_q == ((mode == icc_pkg::ICC_MODE4) ?
                          `ICC_DIV4_LAST : `ICC_DIV16_LAST))
            begin
              cnt_d = 4'h0;
              evt = 1'b1;
            end
            else
            begin
              cnt_d = cnt_q + 4'h1;
            end
          end
        end
        default: evt = 1'b0;
      endcase
    end
  end

  // Registers
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      prev_q <= 1'b0;
      cnt_q <= 4'h0;
    end
    else
    begin
      prev_q <= prev_d;
      cnt_q <= cnt_d;
    end
  end
endmodule
`default_nettype wire

// [hdl/icc_capture.sv]
// Input capture channel with AXI4-Lite register slave
//
// Added by the designer: the register addresses and the AXI4-Lite register port.
`default_nettype none
`include "icc_defines.svh"
module icc_capture #(
  parameter int CW = 16
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Capture pin and timebases
  input wire logic cap_pin,
  input wire logic [CW-1:0] timebase_a_count,
  input wire logic [CW-1:0] timebase_b_count,
  // Power state
  input wire logic cpu_idle,
  input wire logic cpu_sleep,
  // Interrupt request pulse
  output logic irq,
  // AXI4-Lite write address
  input wire logic awvalid,
  output logic awready,
  input wire logic [3:0] awaddr,
  // AXI4-Lite write data
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  // AXI4-Lite write response
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  // AXI4-Lite read address
  input wire logic arvalid,
  output logic arready,
  input wire logic [3:0] araddr,
  // AXI4-Lite read data
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp
);
  localparam int DEPTH = `ICC_BUF_DEPTH;
  // Control register and status
  logic [15:0] ctrl_q, ctrl_d;
  logic ovf_q, ovf_d;
  // Capture buffer
  logic [CW-1:0] mem_q [DEPTH];
  logic [CW-1:0] mem_d [DEPTH];
  logic [1:0] wp_q, wp_d, rp_q, rp_d;
  logic [2:0] cnt_q, cnt_d;
  logic [1:0] cpi_q, cpi_d;
  logic irq_q, irq_d;
  // Bus state
  logic aw_q, aw_d, w_q, w_d, bv_q, bv_d, rv_q, rv_d;
  logic [3:0] awa_q, awa_d;
  logic [31:0] wd_q, wd_d, rd_q, rd_d;
  logic [3:0] ws_q, ws_d;
  logic [1:0] br_q, br_d, rr_q, rr_d;
  // Decoded
  logic [2:0] mode;
  logic run, evt, rise, pop, push, wr_go;
  logic [15:0] wmask;
  logic [15:0] status;

  assign mode = ctrl_q[`ICC_MODE_HI:`ICC_MODE_LO];
  // Idle halt only when the stop bit is set; sleep stops capture modes
  assign run = ~cpu_sleep & ~(cpu_idle & ctrl_q[`ICC_SIDL_BIT]);

  icc_edge_det u_edge (
    .clk(clk),
    .rst(rst),
    .run(run),
    .mode(mode),
    .pin(cap_pin),
    .evt(evt),
    .rise(rise)
  );

  // Status view of the control register
  always_comb
  begin
    status = ctrl_q;
    status[`ICC_OVF_BIT] = ovf_q;
    status[`ICC_BNE_BIT] = (cnt_q != 3'h0);
  end

  // Bus handshakes: each channel accepted while not yet latched, write channels only while no response is pending
  assign awready = ~aw_q & ~bv_q;
  assign wready = ~w_q & ~bv_q;
  assign arready = ~rv_q;
  assign bvalid = bv_q;
  assign bresp = br_q;
  assign rvalid = rv_q;
  assign rdata = rd_q;
  assign rresp = rr_q;
  assign irq = irq_q;
  assign wr_go = aw_q & w_q & ~bv_q;
  // Popping the buffer happens when a buffer read is accepted
  assign pop = arvalid & arready & (araddr == `ICC_BUF_OFS)
               & (cnt_q != 3'h0);
  assign push = evt & (cnt_q != 3'(DEPTH));

  // Next-state logic for bus, control and capture buffer
  always_comb
  begin
    aw_d = aw_q;
    w_d = w_q;
    bv_d = bv_q;
    rv_d = rv_q;
    awa_d = awa_q;
    wd_d = wd_q;
    ws_d = ws_q;
    br_d = br_q;
    rr_d = rr_q;
    rd_d = rd_q;
    ctrl_d = ctrl_q;
    ovf_d = ovf_q;
    wp_d = wp_q;
    rp_d = rp_q;
    cnt_d = cnt_q;
    cpi_d = cpi_q;
    irq_d = 1'b0;
    mem_d = mem_q;
    wmask = {{8{ws_q[1]}}, {8{ws_q[0]}}} & `ICC_CTRL_WMASK;
    if (awvalid & awready)
    begin
      aw_d = 1'b1;
      awa_d = awaddr;
    end
    if (wvalid & wready)
    begin
      w_d = 1'b1;
      wd_d = wdata;
      ws_d = wstrb;
    end
    if (wr_go)
    begin
      aw_d = 1'b0;
      w_d = 1'b0;
      bv_d = 1'b1;
      br_d = `ICC_RESP_OKAY;
      if (awa_q == `ICC_CTRL_OFS)
      begin
        // Flags are masked out so software cannot alter them
        ctrl_d = (ctrl_q & ~wmask) | (wd_q[15:0] & wmask);
        if (ctrl_d[`ICC_MODE_HI:`ICC_MODE_LO] == icc_pkg::ICC_OFF)
        begin
          // Switching off flushes; an overflow in this same cycle still sets
          ovf_d = evt & ~push;
          cnt_d = 3'h0;
          wp_d = 2'h0;
          rp_d = 2'h0;
          cpi_d = 2'h0;
        end
      end
      else if (awa_q != `ICC_BUF_OFS)
      begin
        br_d = `ICC_RESP_SLVERR;
      end
    end
    if (bv_q & bready)
    begin
      bv_d = 1'b0;
    end
    if (arvalid & arready)
    begin
      rv_d = 1'b1;
      rr_d = `ICC_RESP_OKAY;
      rd_d = 32'h0;
      if (araddr == `ICC_CTRL_OFS)
      begin
        rd_d = {16'h0, status};
      end
      else if (araddr == `ICC_BUF_OFS)
      begin
        rd_d = 32'(mem_q[rp_q]);
      end
      else
      begin
        rr_d = `ICC_RESP_SLVERR;
      end
    end
    if (rv_q & rready)
    begin
      rv_d = 1'b0;
    end
    // Capture path; a pop in the same cycle frees no slot for the push
    if (!(wr_go & (awa_q == `ICC_CTRL_OFS)
          & (ctrl_d[`ICC_MODE_HI:`ICC_MODE_LO] == icc_pkg::ICC_OFF)))
    begin
      if (pop)
      begin
        rp_d = rp_q + 2'h1;
      end
      if (push)
      begin
        // Timer select 1 picks timebase A
        mem_d[wp_q] = ctrl_q[`ICC_TSEL_BIT] ?
                      timebase_a_count : timebase_b_count;
        wp_d = wp_q + 2'h1;
        // At or past the field, so a lowered field takes effect at once
        if (cpi_q >= ctrl_q[`ICC_CPI_HI:`ICC_CPI_LO])
        begin
          cpi_d = 2'h0;
          irq_d = 1'b1;
        end
        else
        begin
          cpi_d = cpi_q + 2'h1;
        end
      end
      else if (evt)
      begin
        ovf_d = 1'b1;
      end
      cnt_d = cnt_q + 3'(push) - 3'(pop);
    end
    // Wake pin mode: rising edge in sleep or idle only
    if (mode == icc_pkg::ICC_WAKE_PIN)
    begin
      irq_d = rise & (cpu_sleep | cpu_idle);
    end
  end

  // Register all state
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      ctrl_q <= `ICC_CTRL_RST;
      ovf_q <= 1'b0;
      wp_q <= 2'h0;
      rp_q <= 2'h0;
      cnt_q <= 3'h0;
      cpi_q <= 2'h0;
      irq_q <= 1'b0;
      aw_q <= 1'b0;
      w_q <= 1'b0;
      bv_q <= 1'b0;
      rv_q <= 1'b0;
      awa_q <= 4'h0;
      wd_q <= 32'h0;
      ws_q <= 4'h0;
      br_q <= 2'h0;
      rr_q <= 2'h0;
      rd_q <= 32'h0;
      for (int i = 0; i < DEPTH; i++)
      begin
        mem_q[i] <= '0;
      end
    end
    else
    begin
      ctrl_q <= ctrl_d;
      ovf_q <= ovf_d;
      wp_q <= wp_d;
      rp_q <= rp_d;
      cnt_q <= cnt_d;
      cpi_q <= cpi_d;
      irq_q <= irq_d;
      aw_q <= aw_d;
      w_q <= w_d;
      bv_q <= bv_d;
      rv_q <= rv_d;
      awa_q <= awa_d;
      wd_q <= wd_d;
      ws_q <= ws_d;
      br_q <= br_d;
      rr_q <= rr_d;
      rd_q <= rd_d;
      mem_q <= mem_d;
    end
  end

  // ==========================================================
  // Checks
  a_off_no_irq: assert property (@(posedge clk) disable iff (rst)
    (mode == icc_pkg::ICC_OFF || mode == icc_pkg::ICC_UNUSED) |=> !irq)
    else $error("irq while disabled");
  a_bne_set: assert property (@(posedge clk)
    disable iff (rst) push && !wr_go |=> status[`ICC_BNE_BIT])
    else $error("bne not set");
  a_bne_clear: assert property (@(posedge clk)
    disable iff (rst) pop && !push && cnt_q == 3'h1
    |=> !status[`ICC_BNE_BIT])
    else $error("bne not cleared");
  a_ovf_sticky: assert property (@(posedge clk)
    disable iff (rst) ovf_q && !(wr_go && awa_q == `ICC_CTRL_OFS
    && ctrl_d[`ICC_MODE_HI:`ICC_MODE_LO] == icc_pkg::ICC_OFF)
    |=> ovf_q)
    else $error("ovf lost");
  a_ovf_on_full: assert property (@(posedge clk)
    disable iff (rst) evt && cnt_q == 3'(DEPTH) && !wr_go |=> ovf_q)
    else $error("ovf not set");
  a_cap_sel: assert property (@(posedge clk)
    disable iff (rst) push && !wr_go |=>
    mem_q[$past(wp_q)] == ($past(ctrl_q[`ICC_TSEL_BIT]) ?
      $past(timebase_a_count) : $past(timebase_b_count)))
    else $error("wrong timebase");
  a_every_edge: assert property (@(posedge clk) disable iff (rst)
    run && mode == icc_pkg::ICC_EVERY_EDGE && $changed(cap_pin) |-> evt)
    else $error("edge missed");
  a_wake_rise: assert property (@(posedge clk) disable iff (rst)
    mode == icc_pkg::ICC_WAKE_PIN && rise && cpu_idle |=> irq)
    else $error("wake missed");
  a_idle_halt: assert property (@(posedge clk) disable iff (rst)
    cpu_idle && ctrl_q[`ICC_SIDL_BIT] |-> !evt)
    else $error("ran in idle");
  a_cpi_every: assert property (@(posedge clk) disable iff (rst)
    push && !wr_go && mode != icc_pkg::ICC_WAKE_PIN
    && ctrl_q[`ICC_CPI_HI:`ICC_CPI_LO] == 2'h0 |=> irq)
    else $error("no irq");
  a_rst_zero: assert property (@(posedge clk)
    $past(rst) |-> ctrl_q == `ICC_CTRL_RST)
    else $error("reset value");
endmodule
`default_nettype wire

// [verif/icc_pin_src.sv]
// Signal source model that drives the capture pin
`default_nettype none
module icc_pin_src (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Requested level and lag in cycles
  input wire logic lvl,
  input wire logic [3:0] dly,
  // Capture pin
  output logic pin
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] cnt_q, cnt_d;
  logic pin_q, pin_d;
  // The lag lets one source act prompt or sluggish
  always_comb
  begin
    pin_d = pin_q;
    cnt_d = (lvl != pin_q) ? cnt_q + 4'h1 : 4'h0;
    if (lvl != pin_q && cnt_q >= dly)
      pin_d = lvl;
  end
  // Registered pin, low out of reset
  always_ff @(posedge clk)
  begin
    cnt_q <= rst ? 4'h0 : cnt_d;
    pin_q <= rst ? 1'h0 : pin_d;
  end
  assign pin = pin_q;
endmodule
`default_nettype wire

// [verif/test_icc_capture.sv]
// Register-level testbench for the input capture channel
`default_nettype none
module test_icc_capture;
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================
  // Signals and instances
  logic clk = 1'h0;
  logic rst = 1'h1;
  logic cap_pin, irq, awready, wready, bvalid, arready, rvalid;
  logic lvl = 1'h0;
  logic cpu_idle = 1'h0;
  logic cpu_sleep = 1'h0;
  logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0;
  logic arvalid = 1'h0, rready = 1'h0;
  logic [3:0] dly = 4'h0, awaddr = 4'h0, araddr = 4'h0;
  logic [3:0] wstrb = 4'hf;
  logic [15:0] tba = 16'h1111, tbb = 16'h2222;
  logic [31:0] wdata = 32'h0, rdata, rd_v;
  logic [1:0] bresp, rresp, rd_r;
  int err_total = 0, checks_done = 0, irq_n = 0, i0, c;
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin err_total++; \
  $display("ERROR %0t ns: got %h expected %h", $time, (g), (e)); end end

  always #5 clk = ~clk;
  // Count interrupt pulses, one per cycle at most
  always @(posedge clk) if (irq === 1'h1) irq_n <= irq_n + 1;

  icc_pin_src icc_pin_src_i (.clk(clk), .rst(rst), .lvl(lvl), .dly(dly),
    .pin(cap_pin));
  icc_capture icc_capture_i (.clk(clk), .rst(rst), .cap_pin(cap_pin),
    .timebase_a_count(tba), .timebase_b_count(tbb), .cpu_idle(cpu_idle),
    .cpu_sleep(cpu_sleep), .irq(irq), .awvalid(awvalid),
    .awready(awready), .awaddr(awaddr), .wvalid(wvalid), .wready(wready),
    .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid), .bready(bready),
    .bresp(bresp), .arvalid(arvalid), .arready(arready), .araddr(araddr),
    .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp));

  // ==========================================================
  // Bus and pin tasks
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic fail(input string m);
    err_total++;
    $display("ERROR %0t ns: %s", $time, m);
    tally_and_finish();
  endtask

  // Address and data offered together, each dropped once taken
  task automatic axw(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    repeat (50)
    begin
      @(posedge clk);
      if (awready === 1'h1) awvalid <= 1'h0;
      if (wready === 1'h1) wvalid <= 1'h0;
      if (bvalid === 1'h1)
      begin
        bready <= 1'h0;
        return;
      end
    end
    fail("write timeout");
  endtask

  task automatic axr(input logic [3:0] a);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    repeat (50)
    begin
      @(posedge clk);
      if (arready === 1'h1) arvalid <= 1'h0;
      if (rvalid === 1'h1)
      begin
        rd_v = rdata;
        rd_r = rresp;
        rready <= 1'h0;
        return;
      end
    end
    fail("read timeout");
  endtask

  // Move the pin, then allow the capture to land in the buffer
  task automatic setp(input logic v);
    @(posedge clk);
    lvl <= v;
    for (int n = 0; n < 40 && cap_pin !== v; n++)
      @(posedge clk);
    if (cap_pin !== v)
      fail("pin stuck");
    repeat (3) @(posedge clk);
  endtask

  task automatic pop(input logic [15:0] e);
    axr(4'h4);
    `CHK(rd_v, {16'h0, e})
  endtask

  task automatic st(input logic [1:0] e);
    axr(4'h0);
    `CHK(rd_v[4:3], e)
  endtask

  task automatic note(input string s);
    $display("test %s finished", s);
  endtask

  // ==========================================================
  // Test sequence
  initial
  begin
    repeat (3) @(posedge clk);
    rst <= 1'h0;
    axr(4'h0);
    `CHK(rd_v, 32'h0)
    axw(4'h0, 32'hffff);
    axr(4'h0);
    `CHK(rd_v, 32'h20e7)
    axr(4'h8);
    `CHK(rd_r, 2'h2)
    note("registers");
    axw(4'h0, 32'h81);
    setp(1'h1);
    dly <= 4'h5;
    setp(1'h0);
    st(2'h1);
    pop(tba);
    pop(tba);
    st(2'h0);
    axw(4'h0, 32'h1);
    setp(1'h1);
    pop(tbb);
    note("capture");
    repeat (5) setp(~lvl);
    st(2'h3);
    axw(4'h0, 32'h1);
    st(2'h3);
    axw(4'h0, 32'h0);
    st(2'h0);
    note("overflow");
    for (c = 0; c < 4; c++)
    begin
      axw(4'h0, 32'h0);
      dly <= 4'(c);
      axw(4'h0, 32'(c * 32 + 1));
      i0 = irq_n;
      repeat (12)
      begin
        setp(~lvl);
        pop(tbb);
      end
      `CHK(irq_n - i0, 12 / (c + 1))
    end
    note("interrupts");
    for (c = 0; c < 2; c++)
    begin
      axw(4'h0, c ? 32'h6 : 32'h0);
      i0 = irq_n;
      repeat (2) setp(~lvl);
      st(2'h0);
      `CHK(irq_n, i0)
    end
    note("disabled");
    // Falling, rising, every 4th and every 16th rising, from a low pin
    for (c = 2; c < 6; c++)
    begin
      axw(4'h0, 32'h0);
      setp(1'h0);
      axw(4'h0, 32'(c));
      i0 = irq_n;
      repeat (c < 4 ? 3 : (c == 4 ? 9 : 33)) setp(~lvl);
      `CHK(irq_n - i0, (c == 3) ? 2 : 1)
      st(2'h1);
    end
    axw(4'h0, 32'h0);
    note("modes");
    axw(4'h0, 32'h2067);
    setp(1'h0);
    i0 = irq_n;
    setp(1'h1);
    `CHK(irq_n, i0)
    cpu_sleep <= 1'h1;
    setp(1'h0);
    setp(1'h1);
    `CHK(irq_n, i0 + 1)
    cpu_sleep <= 1'h0;
    cpu_idle <= 1'h1;
    setp(1'h0);
    setp(1'h1);
    `CHK(irq_n, i0 + 2)
    st(2'h0);
    note("wake pin");
    axw(4'h0, 32'h2001);
    setp(1'h0);
    st(2'h0);
    cpu_idle <= 1'h0;
    setp(1'h1);
    st(2'h1);
    cpu_idle <= 1'h1;
    axw(4'h0, 32'h1);
    setp(1'h0);
    pop(tbb);
    st(2'h1);
    note("idle");
    tally_and_finish();
  end
endmodule
`default_nettype wire
